// ==== ufb_defines.svh ====
`ifndef UFB_DEFINES_SVH
`define UFB_DEFINES_SVH

// register offsets on the host bus
`define UFB_ADDR_DIV_LOW 3'h0
`define UFB_ADDR_DIV_HIGH 3'h1
`define UFB_ADDR_FRACTION 3'h2
`define UFB_ADDR_FIFO_CTRL 3'h2
`define UFB_ADDR_LINE_CTRL 3'h3
`define UFB_ADDR_MODEM_CTRL 3'h4

// reset values
`define UFB_RST_DIV_LOW 8'h01
`define UFB_RST_DIV_HIGH 8'h00
`define UFB_RST_FRACTION 8'h00
`define UFB_RST_CTRL 8'h00
`define UFB_RST_PINS 15'h7800

// field positions
`define UFB_BIT_PRESCALE 7
`define UFB_BIT_DIV_ACCESS 7
`define UFB_BIT_FIFO_EN 0
`define UFB_FRAC_MSB 3
`define UFB_SMP_MSB 5
`define UFB_SMP_LSB 4
`define UFB_FRACTION_MASK 8'h3f

// sampling modes and sampling ticks per bit
`define UFB_SMP_16X 2'h0
`define UFB_SMP_8X 2'h1
`define UFB_SMP_4X 2'h2
`define UFB_TICKS_16X 5'h10
`define UFB_TICKS_8X 5'h08
`define UFB_TICKS_4X 5'h04

// prescaler: last count of the divide-by-four cycle
`define UFB_PRESCALE_LAST 2'h3

// input clock limits in MHz, and the core clock
`define UFB_OSC_MAX_MHZ 24
`define UFB_EXT_MAX_MHZ 64
`define UFB_CLK_MHZ 200

`endif

// ==== ufb_pkg.sv ====
package ufb_pkg;
   typedef logic [7:0] ufb_byte_t;
   typedef logic [16:0] ufb_count_t;
   typedef logic [4:0] ufb_level_t;
endpackage : ufb_pkg

// ==== ufb_rate_divider.sv ====
`timescale 1ns/100ps
`include "ufb_defines.svh"

module ufb_rate_divider (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // divisor settings
   input wire logic prescale_by_four,
   input wire logic [15:0] div_int,
   input wire logic [3:0] div_frac,
   input wire logic [1:0] sampling_mode,
   // sampling clock enables
   output logic sample_tick,
   output logic bit_tick
);
   logic [1:0] pre_cnt;
   logic pre_tick;
   logic [3:0] phase;
   logic [3:0] phase_rev;
   logic stretch;
   ufb_pkg::ufb_count_t base;
   ufb_pkg::ufb_count_t period;
   ufb_pkg::ufb_count_t cnt;
   logic fire;
   logic [4:0] ticks_per_bit;
   logic [4:0] bit_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler: every clock with ce high is one oscillator clock; nothing here checks it against the limits
   assign pre_tick = ce && (!prescale_by_four || pre_cnt == `UFB_PRESCALE_LAST);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pre_cnt <= 2'h0;
      end else if (ce) begin
         pre_cnt <= prescale_by_four ? pre_cnt + 2'h1 : 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit-reversed phase spreads the stretched periods evenly over sixteen
   assign phase_rev = {phase[0], phase[1], phase[2], phase[3]};
   assign stretch = phase_rev < div_frac;
   // a zero integer part behaves as one so the output never stops
   assign base = (div_int == 16'h0000) ? 17'h00001 : {1'b0, div_int};
   assign period = base + {16'h0000, stretch};
   assign fire = pre_tick && cnt <= 17'h00001;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 17'h00000;
         phase <= 4'h0;
      end else if (pre_tick) begin
         cnt <= fire ? period : cnt - 17'h00001;
         if (fire) begin
            phase <= phase + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sampling rate: fewer ticks per bit means a faster bit for the same divisor
   always_comb begin
      if (sampling_mode == `UFB_SMP_8X) begin
         ticks_per_bit = `UFB_TICKS_8X;
      end else if (sampling_mode == `UFB_SMP_4X) begin
         ticks_per_bit = `UFB_TICKS_4X;
      end else begin
         ticks_per_bit = `UFB_TICKS_16X; // reserved code falls back to 16x
      end
   end

   // odd fractions at 8x or 4x give a bit-time jitter of one prescaled clock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bit_cnt <= 5'h00;
         sample_tick <= 1'b0;
         bit_tick <= 1'b0;
      end else if (ce) begin
         sample_tick <= fire;
         bit_tick <= fire && bit_cnt + 5'h01 >= ticks_per_bit;
         if (fire) begin
            bit_cnt <= (bit_cnt + 5'h01 >= ticks_per_bit) ? 5'h00 : bit_cnt + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks: prescaled ticks per period, fraction per group, divide by four
   ufb_pkg::ufb_count_t pt_since;
   ufb_pkg::ufb_count_t last_load;
   logic primed;
   logic [4:0] stretch_sum;
   logic group_clean;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pt_since <= 17'h00000;
         last_load <= 17'h00000;
         primed <= 1'b0;
         stretch_sum <= 5'h00;
         group_clean <= 1'b0;
      end else if (ce) begin
         if (pre_tick) begin
            pt_since <= fire ? 17'h00000 : pt_since + 17'h00001;
            if (fire) begin
               last_load <= period;
               primed <= 1'b1;
               stretch_sum <= (phase == 4'hf) ? 5'h00 : stretch_sum + {4'h0, stretch};
            end
         end
         // watched every clock with ce high: a fraction write between prescaled ticks spoils the group
         group_clean <= (fire && phase == 4'hf) ? 1'b1 : group_clean && $stable(div_frac);
      end
   end

   a_period_length: assert property (@(posedge clk) disable iff (reset)
      fire && primed && $stable(div_int) |-> pt_since + 17'h00001 == last_load)
      else $error("sampling period differs from programmed divisor");

   a_fraction_average: assert property (@(posedge clk) disable iff (reset)
      fire && phase == 4'hf && group_clean && $stable(div_frac)
      |-> stretch_sum + {4'h0, stretch} == {1'b0, div_frac})
      else $error("stretched periods per group differ from fraction");

   a_prescale_four: assert property (@(posedge clk) disable iff (reset)
      pre_tick && prescale_by_four ##1 (ce && prescale_by_four)[*4]
      |-> pre_tick && !$past(pre_tick))
      else $error("prescaler is not dividing by four");

   a_bit_needs_sample: assert property (@(posedge clk) disable iff (reset)
      bit_tick |-> sample_tick)
      else $error("bit tick without sampling tick");

   c_prescaled_tick: cover property (@(posedge clk) disable iff (reset)
      fire && prescale_by_four);
   c_fraction_4x: cover property (@(posedge clk) disable iff (reset)
      bit_tick && sampling_mode == `UFB_SMP_4X && div_frac[0]);
endmodule : ufb_rate_divider

// ==== ufb_channel_clocking.sv ====
`timescale 1ns/100ps
`include "ufb_defines.svh"

// How it works
// - receive pin high at one byte or trigger
// - transmit pin low at or above trigger, else high
// - one oscillator clocks both channels' dividers
// - divider runs up to oscillator or external rate
// - each channel owns divider and prescaler
// - modem control bit seven prescales by four
// - divisor from one to sixteen-bit, sixteenth steps
// - divider output is the sampling clock
// - reset gives divisor one: 01, 00, 00
// - two integer bytes, four fraction bits
// - fraction bits 5:4 pick 16x, 8x, 4x
// - odd fraction at 8x/4x may jitter
module ufb_channel_clocking (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // host bus pins, asynchronous to clk
   input wire logic [1:0] cs_n,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // fifo fill state from the channel datapaths
   input wire logic [1:0][4:0] rx_fill,
   input wire logic [1:0][4:0] rx_trigger,
   input wire logic [1:0][4:0] tx_fill,
   input wire logic [1:0][4:0] tx_trigger,
   // sampling clock enables to the shifters
   output logic [1:0] sample_tick,
   output logic [1:0] bit_tick,
   // interrupt pins
   output logic channel_one_interrupt_pin,
   output logic channel_two_interrupt_pin
);
   logic [14:0] pin_meta;
   logic [14:0] pin_sync;
   logic [1:0] s_cs_n;
   logic s_ior_n;
   logic s_iow_n;
   logic [2:0] s_addr;
   ufb_pkg::ufb_byte_t s_data;
   logic iow_prev;
   logic wr_commit;
   logic [1:0] wr_cs_n;
   logic [2:0] wr_addr;
   ufb_pkg::ufb_byte_t wr_data;
   logic rd_active;
   logic rd_ch;
   ufb_pkg::ufb_byte_t divisor_low_byte [2];
   ufb_pkg::ufb_byte_t divisor_high_byte [2];
   ufb_pkg::ufb_byte_t divisor_fraction_and_sampling [2];
   ufb_pkg::ufb_byte_t line_control [2];
   ufb_pkg::ufb_byte_t modem_control_register [2];
   logic [1:0] fifo_enable;
   logic [1:0] int_level;
   logic [1:0] next_int_level;
   ufb_pkg::ufb_byte_t next_data_out;

   ////////////////////////////////////////////////////////////////////////////
   // bus pins pass two flops; the first stage feeds nothing but the second
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_meta <= `UFB_RST_PINS;
         pin_sync <= `UFB_RST_PINS;
      end else if (ce) begin
         pin_meta <= {cs_n, ior_n, iow_n, addr, data_in};
         pin_sync <= pin_meta;
      end
   end

   assign s_cs_n = pin_sync[14:13];
   assign s_ior_n = pin_sync[12];
   assign s_iow_n = pin_sync[11];
   assign s_addr = pin_sync[10:8];
   assign s_data = pin_sync[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // capture address and data while the strobe is low, commit on its rise;
   // data may already be changing when the strobe ends, so it is not used then
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         iow_prev <= 1'b1;
         wr_cs_n <= 2'h3;
         wr_addr <= 3'h0;
         wr_data <= 8'h00;
      end else if (ce) begin
         iow_prev <= s_iow_n;
         if (!s_iow_n) begin
            wr_cs_n <= s_cs_n;
            wr_addr <= s_addr;
            wr_data <= s_data;
         end
      end
   end

   assign wr_commit = ce && s_iow_n && !iow_prev;

   ////////////////////////////////////////////////////////////////////////////
   // per-channel register file; selecting both channels writes both
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int ch = 0; ch < 2; ch++) begin
            divisor_low_byte[ch] <= `UFB_RST_DIV_LOW;
            divisor_high_byte[ch] <= `UFB_RST_DIV_HIGH;
            divisor_fraction_and_sampling[ch] <= `UFB_RST_FRACTION;
            line_control[ch] <= `UFB_RST_CTRL;
            modem_control_register[ch] <= `UFB_RST_CTRL;
            fifo_enable[ch] <= 1'b0;
         end
      end else if (wr_commit) begin
         for (int ch = 0; ch < 2; ch++) begin
            if (wr_cs_n[ch]) begin
               // channel not selected
            end else if (line_control[ch][`UFB_BIT_DIV_ACCESS]
                         && wr_addr == `UFB_ADDR_DIV_LOW) begin
               divisor_low_byte[ch] <= wr_data;
            end else if (line_control[ch][`UFB_BIT_DIV_ACCESS]
                         && wr_addr == `UFB_ADDR_DIV_HIGH) begin
               divisor_high_byte[ch] <= wr_data;
            end else if (line_control[ch][`UFB_BIT_DIV_ACCESS]
                         && wr_addr == `UFB_ADDR_FRACTION) begin
               divisor_fraction_and_sampling[ch] <= wr_data & `UFB_FRACTION_MASK;
            end else if (wr_addr == `UFB_ADDR_FIFO_CTRL) begin
               fifo_enable[ch] <= wr_data[`UFB_BIT_FIFO_EN];
            end else if (wr_addr == `UFB_ADDR_LINE_CTRL) begin
               line_control[ch] <= wr_data;
            end else if (wr_addr == `UFB_ADDR_MODEM_CTRL) begin
               modem_control_register[ch] <= wr_data;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: channel one wins if both are selected, unmapped reads zero
   assign rd_active = !s_ior_n && s_cs_n != 2'h3;
   assign rd_ch = s_cs_n[0];

   always_comb begin
      next_data_out = 8'h00;
      if (line_control[rd_ch][`UFB_BIT_DIV_ACCESS] && s_addr == `UFB_ADDR_DIV_LOW) begin
         next_data_out = divisor_low_byte[rd_ch];
      end else if (line_control[rd_ch][`UFB_BIT_DIV_ACCESS]
                   && s_addr == `UFB_ADDR_DIV_HIGH) begin
         next_data_out = divisor_high_byte[rd_ch];
      end else if (line_control[rd_ch][`UFB_BIT_DIV_ACCESS]
                   && s_addr == `UFB_ADDR_FRACTION) begin
         next_data_out = divisor_fraction_and_sampling[rd_ch];
      end else if (s_addr == `UFB_ADDR_LINE_CTRL) begin
         next_data_out = line_control[rd_ch];
      end else if (s_addr == `UFB_ADDR_MODEM_CTRL) begin
         next_data_out = modem_control_register[rd_ch];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else if (ce) begin
         data_out <= rd_active ? next_data_out : 8'h00;
         data_oe <= rd_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one divider per channel, both on the single oscillator clock
   for (genvar ch = 0; ch < 2; ch++) begin : g_divider
      ufb_rate_divider u_rate_divider (
         .clk(clk),
         .reset(reset),
         .ce(ce),
         .prescale_by_four(modem_control_register[ch][`UFB_BIT_PRESCALE]),
         .div_int({divisor_high_byte[ch], divisor_low_byte[ch]}),
         .div_frac(divisor_fraction_and_sampling[ch][`UFB_FRAC_MSB:0]),
         .sampling_mode(divisor_fraction_and_sampling[ch][`UFB_SMP_MSB:`UFB_SMP_LSB]),
         .sample_tick(sample_tick[ch]),
         .bit_tick(bit_tick[ch])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pin level: receive and transmit contributions or-ed together
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         if (fifo_enable[ch]) begin
            next_int_level[ch] = rx_fill[ch] >= rx_trigger[ch]
               || tx_fill[ch] < tx_trigger[ch];
         end else begin
            next_int_level[ch] = rx_fill[ch] != 5'h00 || tx_fill[ch] == 5'h00;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         int_level <= 2'h0;
      end else if (ce) begin
         int_level <= next_int_level;
      end
   end

   assign channel_one_interrupt_pin = int_level[0];
   assign channel_two_interrupt_pin = int_level[1];

   ////////////////////////////////////////////////////////////////////////////
   // checks on the register file and the interrupt pins
   logic [1:0] written;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         written <= 2'h0;
      end else if (wr_commit) begin
         written <= written | ~wr_cs_n;
      end
   end

   a_reset_divisor: assert property (@(posedge clk) disable iff (reset)
      !written[0] |-> divisor_low_byte[0] == `UFB_RST_DIV_LOW
         && divisor_high_byte[0] == `UFB_RST_DIV_HIGH
         && divisor_fraction_and_sampling[0] == `UFB_RST_FRACTION)
      else $error("divisor not at reset value before first write");

   a_rx_fifo_level: assert property (@(posedge clk) disable iff (reset)
      ce && fifo_enable[1] && rx_fill[1] >= rx_trigger[1] ##1 ce
      |-> channel_two_interrupt_pin)
      else $error("interrupt pin low with receive fifo at trigger");

   a_tx_idle_low: assert property (@(posedge clk) disable iff (reset)
      ce && fifo_enable[0] && tx_fill[0] >= tx_trigger[0] && rx_fill[0] < rx_trigger[0]
      |=> !channel_one_interrupt_pin || !ce)
      else $error("interrupt pin high with transmit fifo above trigger");

   a_single_byte: assert property (@(posedge clk) disable iff (reset)
      ce && !fifo_enable[0] && rx_fill[0] == 5'h00 && tx_fill[0] != 5'h00
      |=> !channel_one_interrupt_pin || !ce)
      else $error("interrupt pin high with no data held");

   a_prescale_write: assert property (@(posedge clk) disable iff (reset)
      wr_commit && !wr_cs_n[0] && wr_addr == `UFB_ADDR_MODEM_CTRL
      |=> modem_control_register[0][`UFB_BIT_PRESCALE] == $past(wr_data[7]))
      else $error("prescaler select not written");

   a_fraction_mask: assert property (@(posedge clk) disable iff (reset)
      divisor_fraction_and_sampling[0][7:6] == 2'h0
         && divisor_fraction_and_sampling[1][7:6] == 2'h0)
      else $error("unimplemented fraction bits set");

   c_int_rise: cover property (@(posedge clk) disable iff (reset)
      $rose(channel_one_interrupt_pin));
   c_both_written: cover property (@(posedge clk) disable iff (reset)
      wr_commit && wr_cs_n == 2'h0);
endmodule : ufb_channel_clocking

// ==== ufb_host_model.sv ====
`timescale 1ns/100ps
// host processor on the asynchronous register bus; paced by clk only for convenience
module ufb_host_model (
   // pacing clock
   input wire logic clk,
   // pins driven by the host
   output logic [1:0] cs_n,
   output logic ior_n,
   output logic iow_n,
   output logic [2:0] addr,
   output logic [7:0] data_in,
   // pins driven by the device
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   // idle bus: nothing selected, no strobe
   initial begin
      cs_n = 2'h3;
      ior_n = 1'b1;
      iow_n = 1'b1;
      addr = 3'h0;
      data_in = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // strobes held four clocks high, low four on write and five on read, above the three the sync needs
   task automatic write_reg(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      cs_n = sel;
      addr = a;
      data_in = d;
      iow_n = 1'b0;
      repeat (4) @(negedge clk);
      iow_n = 1'b1;
      repeat (4) @(negedge clk);
      // released bus shows the inverse, never a stale copy that could pass by luck
      cs_n = 2'h3;
      data_in = ~d;
      repeat (4) @(negedge clk);
   endtask : write_reg

   task automatic read_reg(input logic [1:0] sel, input logic [2:0] a,
                           output logic [7:0] d, output logic oe);
      @(negedge clk);
      cs_n = sel;
      addr = a;
      ior_n = 1'b0;
      repeat (5) @(negedge clk);
      d = data_out;
      oe = data_oe;
      ior_n = 1'b1;
      repeat (4) @(negedge clk);
      cs_n = 2'h3;
   endtask : read_reg

   ////////////////////////////////////////////////////////////////////////////
   // divisor in sixteenths from input clock, prescale, rate and oversampling
   function automatic logic [19:0] calc_div_q4(input longint hz, input longint pre,
                                               input longint rate, input longint os);
      return 20'((hz * 16 / pre + rate * os / 2) / (rate * os));
   endfunction : calc_div_q4

   // split into high, low and fraction bytes; sampling mode rides in bits 5:4
   task automatic set_divisor(input logic [1:0] sel, input logic [19:0] q4,
                              input logic [1:0] mode);
      write_reg(sel, 3'h1, q4[19:12]);
      write_reg(sel, 3'h0, q4[11:4]);
      write_reg(sel, 3'h2, {2'h0, mode, q4[3:0]});
   endtask : set_divisor
endmodule : ufb_host_model

// ==== uart_fractional_baud_generator_test.sv ====
`timescale 1ns/100ps
module uart_fractional_baud_generator_test;
   logic clk;
   logic reset;
   logic ce;
   logic [1:0] cs_n;
   logic ior_n;
   logic iow_n;
   logic [2:0] addr;
   logic [7:0] data_in;
   logic [7:0] data_out;
   logic data_oe;
   logic [1:0][4:0] rx_fill;
   logic [1:0][4:0] rx_trigger;
   logic [1:0][4:0] tx_fill;
   logic [1:0][4:0] tx_trigger;
   logic [1:0] sample_tick;
   logic [1:0] bit_tick;
   logic channel_one_interrupt_pin;
   logic channel_two_interrupt_pin;
   int bad_count;
   int n_compared;
   logic [7:0] rd;
   logic oe;
   int clocks;
   int bits;

   ufb_channel_clocking uut (.clk(clk), .reset(reset), .ce(ce), .cs_n(cs_n), .ior_n(ior_n),
      .iow_n(iow_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .rx_fill(rx_fill), .rx_trigger(rx_trigger), .tx_fill(tx_fill), .tx_trigger(tx_trigger),
      .sample_tick(sample_tick), .bit_tick(bit_tick),
      .channel_one_interrupt_pin(channel_one_interrupt_pin),
      .channel_two_interrupt_pin(channel_two_interrupt_pin));

   ufb_host_model host (.clk(clk), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

   // 200 mhz core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compared %0d, mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte

   task automatic check_pin(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask : check_pin

   task automatic check_count(input string what, input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         bad_count++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_count

   task automatic timeout(input string what);
      bad_count++;
      $display("BAD %s expected tick seen none", what);
      give_verdict();
   endtask : timeout

   // clocks spanned by 16 sampling periods, and bit ticks among them
   task automatic measure(input int ch, output int n_clk, output int n_bit);
      int ticks;
      ticks = 0;
      n_clk = 0;
      n_bit = 0;
      // skip periods that may straddle the last register write
      while (ticks < 3) begin
         @(negedge clk);
         n_clk++;
         if (sample_tick[ch] === 1'b1) ticks++;
         if (n_clk > 20000) timeout("sample tick");
      end
      ticks = 0;
      n_clk = 0;
      while (ticks < 16) begin
         @(negedge clk);
         n_clk++;
         if (sample_tick[ch] === 1'b1) ticks++;
         if (bit_tick[ch] === 1'b1) n_bit++;
         if (n_clk > 20000) timeout("sample tick");
      end
   endtask : measure

   ////////////////////////////////////////////////////////////////////////////
   // reset values through divisor access, plus an unmapped read
   task automatic t_reset_values();
      host.write_reg(2'h0, 3'h3, 8'h80);
      host.read_reg(2'h2, 3'h0, rd, oe);
      check_byte("divisor low", 8'h01, rd);
      check_pin("read enable", 1'b1, oe);
      host.read_reg(2'h2, 3'h1, rd, oe);
      check_byte("divisor high", 8'h00, rd);
      host.read_reg(2'h2, 3'h2, rd, oe);
      check_byte("fraction", 8'h00, rd);
      host.read_reg(2'h2, 3'h5, rd, oe);
      check_byte("unmapped", 8'h00, rd);
   endtask : t_reset_values

   // a divisor of 53/16 must average out over a group of sixteen periods
   task automatic t_fraction();
      host.set_divisor(2'h2, host.calc_div_q4(200000000, 1, 3773585, 16), 2'h0);
      host.read_reg(2'h2, 3'h2, rd, oe);
      check_byte("fraction readback", 8'h05, rd);
      measure(0, clocks, bits);
      check_count("clocks per 16 samples", 53, clocks);
      check_count("bits per 16 samples 16x", 1, bits);
      host.write_reg(2'h2, 3'h2, 8'hff);
      host.read_reg(2'h2, 3'h2, rd, oe);
      check_byte("fraction upper bits", 8'h3f, rd);
      // reserved sampling code runs as 16x; 3 + 15/16 per period
      measure(0, clocks, bits);
      check_count("clocks reserved mode", 63, clocks);
      check_count("bits reserved mode", 1, bits);
   endtask : t_fraction

   // 4 + 2/16 in every mode; period is the same, bit length shrinks
   task automatic t_modes();
      for (int m = 0; m < 3; m++) begin
         host.set_divisor(2'h2, 20'h00042, 2'(m));
         measure(0, clocks, bits);
         check_count("clocks per 16 samples", 66, clocks);
         check_count("bits per 16 samples", 1 << m, bits);
      end
   endtask : t_modes

   // prescale on channel one only; channel two first keeps its reset divisor of one, then gets 258
   task automatic t_prescale();
      host.set_divisor(2'h2, 20'h00030, 2'h0);
      host.write_reg(2'h2, 3'h4, 8'h80);
      measure(0, clocks, bits);
      check_count("prescaled clocks", 192, clocks);
      measure(1, clocks, bits);
      check_count("channel two default", 16, clocks);
      check_count("channel two bits", 1, bits);
      host.set_divisor(2'h1, 20'h01020, 2'h0);
      measure(1, clocks, bits);
      check_count("channel two high byte", 4128, clocks);
      host.write_reg(2'h2, 3'h4, 8'h00);
      measure(0, clocks, bits);
      check_count("prescale cleared", 48, clocks);
   endtask : t_prescale

   // clock enable low stops both generators
   task automatic t_freeze();
      int n;
      int w;
      n = 0;
      w = 0;
      // freeze where no tick stands: a frozen output holds its level
      @(negedge clk);
      while (sample_tick !== 2'h0) begin
         @(negedge clk);
         w++;
         if (w > 1000) timeout("idle sample tick");
      end
      ce = 1'b0;
      repeat (2) @(negedge clk);
      repeat (40) begin
         @(negedge clk);
         if (sample_tick !== 2'h0) n++;
      end
      ce = 1'b1;
      check_count("ticks while frozen", 0, n);
      measure(0, clocks, bits);
      check_count("clocks after thaw", 48, clocks);
   endtask : t_freeze

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pin cases {rx, rx trigger, tx, tx trigger}
   localparam logic [19:0] CASES [6] = '{{5'h0, 5'h4, 5'h3, 5'h8}, {5'h1, 5'h4, 5'h8, 5'h8},
      {5'h0, 5'h4, 5'h0, 5'h8}, {5'h3, 5'h4, 5'h8, 5'h8}, {5'h4, 5'h4, 5'h9, 5'h8},
      {5'h0, 5'h4, 5'h7, 5'h8}};

   function automatic logic pin_level(input logic fifo_on, input logic [19:0] c);
      if (fifo_on) return (c[19:15] >= c[14:10]) || (c[9:5] < c[4:0]);
      return (c[19:15] != 5'h0) || (c[9:5] == 5'h0);
   endfunction : pin_level

   // channel two gets the next case so the two pins must differ at times
   task automatic run_pins(input logic fifo_on);
      int j;
      for (int i = 0; i < 6; i++) begin
         j = (i + 1) % 6;
         @(negedge clk);
         {rx_fill[0], rx_trigger[0], tx_fill[0], tx_trigger[0]} = CASES[i];
         {rx_fill[1], rx_trigger[1], tx_fill[1], tx_trigger[1]} = CASES[j];
         repeat (2) @(negedge clk);
         check_pin("pin one", pin_level(fifo_on, CASES[i]), channel_one_interrupt_pin);
         check_pin("pin two", pin_level(fifo_on, CASES[j]), channel_two_interrupt_pin);
      end
   endtask : run_pins

   task automatic t_interrupts();
      run_pins(1'b0);
      host.write_reg(2'h0, 3'h3, 8'h00);
      host.write_reg(2'h0, 3'h2, 8'h01);
      run_pins(1'b1);
   endtask : t_interrupts

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      bad_count = 0;
      n_compared = 0;
      reset = 1'b1;
      ce = 1'b1;
      rx_fill = '0;
      rx_trigger = '0;
      tx_fill = '0;
      tx_trigger = '0;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      t_reset_values();
      t_fraction();
      t_modes();
      t_prescale();
      t_freeze();
      t_interrupts();
      give_verdict();
   end
endmodule : uart_fractional_baud_generator_test
